// ### hdl/chipset_config_registers.sv
// indexed configuration register bank with decoded settings
// Summary of operation
// R1 - index at port 22h, one access at 23h
// R2 - index cleared after every data access
// R3 - reg50 bit5 picks write cas width
// R4 - reg50 code picks four bank sizes
// R5 - reg51 cache enable, policy, interleave, on/off
// R6 - reg51 bits 5:4 encode cache size
// R7 - reg51 bit0 burst read 1t or 2t
// R8 - reg52 shadow read and write protect
// R9 - reg52 low six bits enable shadow segments
// R10 - rom size and two extra rom segments
// R11 - bios and c0000 segment cacheable bits
// R12 - reg53 supplies a25 a24 for dma
// R13 - reg53 bit1 enables data parity check
// R14 - turbo force, software de-turbo, hold time
// R15 - noncacheable area to dram or at bus
// R16 - noncacheable area size, 000 disables it
// R17 - noncacheable area base address bits
// R18 - reg57 bit5 enables gate a20 emulation
// R19 - fast reset emulation and its latency
// R20 - reg57 bit2 selects quarter rate refresh
// R21 - reg57 bit0 forces cache hit for sizing
// R22 - dram write wait state and slow cpu
// R23 - reg60 selects at bus clock source
// R24 - reg61 io recovery times in bus clocks
// R25 - reg61 wait states for 16 and 8 bit
// R26 - reset loads every register default
`timescale 1ns/100ps
module chipset_config_registers
  import cfg_regs_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [15:0] IO_ADDR,
  input  wire logic        IO_WR,
  input  wire logic        IO_RD,
  input  wire logic [7:0]  IO_WDATA,
  output logic      [7:0]  IO_RDATA,
  output logic             IO_RVALID,
  input  wire logic        DETURBO_SW,
  output logic             CAS_WR_1T,
  output logic      [4:0]  BANK0_MB,
  output logic      [4:0]  BANK1_MB,
  output logic      [4:0]  BANK2_MB,
  output logic      [4:0]  BANK3_MB,
  output logic      [6:0]  TOTAL_MB,
  output logic             CACHE_EN,
  output logic             CACHE_WB,
  output logic      [1:0]  CACHE_SIZE,
  output logic             CACHE_INTLV,
  output logic             CACHE_ON,
  output logic             CACHE_WR_2T,
  output logic             CACHE_BURST_2T,
  output logic             FORCE_HIT,
  output logic             SHADOW_RD_EN,
  output logic             SHADOW_WP,
  output logic      [5:0]  SHADOW_SEG,
  output logic             ROM_128K,
  output logic             ROM_MERGE_C0,
  output logic             ROM_MERGE_C8,
  output logic             BIOS_CACHEABLE,
  output logic             C0_CACHEABLE,
  output logic      [1:0]  DMA_A25_24,
  output logic             PARITY_EN,
  output logic             DETURBO,
  output logic      [11:0] DETURBO_HOLD_CYC,
  output logic      [11:0] DETURBO_PERIOD_CYC,
  output logic             NC1_TO_AT,
  output logic      [6:0]  NC1_SIZE_64K,
  output logic      [9:0]  NC1_BASE,
  output logic             NC2_TO_AT,
  output logic      [6:0]  NC2_SIZE_64K,
  output logic      [9:0]  NC2_BASE,
  output logic             A20_EMU_EN,
  output logic             FAST_RST_EN,
  output logic      [11:0] FAST_RST_LAT_CYC,
  output logic             SLOW_REFRESH,
  output logic             SLOW_CPU,
  output logic             DRAM_WR_0WS,
  output logic             AT_CLK_FIXED,
  output logic      [3:0]  AT_CLK_DIV,
  output logic      [3:0]  IO16_RECOVERY,
  output logic      [4:0]  IO8_RECOVERY,
  output logic      [1:0]  WAIT16,
  output logic      [2:0]  WAIT8
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    logic [7:0]                idx;
    logic                      idx_vld;
    logic [NUM_REGS-1:0][7:0]  regs;
    logic [7:0]                rdata;
    logic                      rvalid;
    logic                      sw_meta;
    logic                      sw_sync;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  logic [7:0] r_dram;
  logic [7:0] r_cache;
  logic [7:0] r_shad;
  logic [7:0] r_rom;
  logic [7:0] r_ncsz;
  logic [7:0] r_emu;
  logic [7:0] r_misc;
  logic [7:0] r_bclk;
  logic [7:0] r_brec;
  logic [19:0] banks;
  logic        wr_index;
  logic        acc_data;
  logic [4:0]  slot_hit;

  // ***********************************************************
  // decode functions
  // ***********************************************************
  // index to storage slot; bit 4 flags a mapped index
  function automatic logic [4:0] slot_of(input logic [7:0] idx);
    logic [4:0] s;
    s = 5'h00;
    if (idx == IDX_DRAM) s = {1'b1, S_DRAM};
    else if (idx == IDX_CACHE) s = {1'b1, S_CACHE};
    else if (idx == IDX_SHAD) s = {1'b1, S_SHAD};
    else if (idx == IDX_ROM) s = {1'b1, S_ROM};
    else if (idx == IDX_NCSZ) s = {1'b1, S_NCSZ};
    else if (idx == IDX_NC1B) s = {1'b1, S_NC1B};
    else if (idx == IDX_NC2B) s = {1'b1, S_NC2B};
    else if (idx == IDX_EMU) s = {1'b1, S_EMU};
    else if (idx == IDX_MISC) s = {1'b1, S_MISC};
    else if (idx == IDX_BCLK) s = {1'b1, S_BCLK};
    else if (idx == IDX_BREC) s = {1'b1, S_BREC};
    return s;
  endfunction

  // noncacheable size in 64kb units, code 000 means disabled
  function automatic logic [6:0] nc_size(input logic [2:0] code);
    logic [6:0] sz;
    sz = 7'h00;
    if (code != 3'h0) sz = 7'(7'h01 << (code - 3'h1));
    return sz;
  endfunction

  // bank sizes in mb, packed {bank3, bank2, bank1, bank0}
  function automatic logic [19:0] bank_map(input logic [4:0] code);
    logic [19:0] f;
    f = 20'h0_0000;
    case (code)
      5'h00: f = {5'h00, 5'h00, 5'h00, 5'h01};
      5'h01: f = {5'h00, 5'h00, 5'h01, 5'h01};
      5'h02: f = {5'h00, 5'h02, 5'h01, 5'h01};
      5'h03: f = {5'h00, 5'h04, 5'h01, 5'h01};
      5'h04: f = {5'h04, 5'h02, 5'h01, 5'h01};
      5'h05: f = {5'h04, 5'h04, 5'h01, 5'h01};
      5'h06: f = {5'h00, 5'h10, 5'h01, 5'h01};
      5'h07: f = {5'h00, 5'h00, 5'h00, 5'h02};
      5'h08: f = {5'h00, 5'h00, 5'h02, 5'h02};
      5'h09: f = {5'h00, 5'h00, 5'h04, 5'h02};
      5'h0A: f = {5'h00, 5'h04, 5'h02, 5'h02};
      5'h0B: f = {5'h04, 5'h04, 5'h02, 5'h02};
      5'h0C: f = {5'h00, 5'h00, 5'h10, 5'h02};
      5'h0D: f = {5'h00, 5'h10, 5'h02, 5'h02};
      5'h0E: f = {5'h10, 5'h04, 5'h02, 5'h02};
      5'h0F: f = {5'h10, 5'h10, 5'h02, 5'h02};
      5'h10: f = {5'h00, 5'h00, 5'h00, 5'h04};
      5'h11: f = {5'h00, 5'h00, 5'h04, 5'h04};
      5'h12: f = {5'h00, 5'h04, 5'h04, 5'h04};
      5'h13: f = {5'h04, 5'h04, 5'h04, 5'h04};
      5'h14: f = {5'h00, 5'h00, 5'h10, 5'h04};
      5'h15: f = {5'h00, 5'h10, 5'h04, 5'h04};
      5'h16: f = {5'h00, 5'h10, 5'h10, 5'h04};
      5'h17: f = {5'h10, 5'h10, 5'h04, 5'h04};
      5'h18: f = {5'h00, 5'h00, 5'h00, 5'h08};
      5'h19: f = {5'h00, 5'h00, 5'h08, 5'h08};
      5'h1A: f = {5'h00, 5'h08, 5'h08, 5'h08};
      5'h1B: f = {5'h08, 5'h08, 5'h08, 5'h08};
      5'h1C: f = {5'h00, 5'h00, 5'h00, 5'h10};
      5'h1D: f = {5'h00, 5'h00, 5'h10, 5'h10};
      5'h1E: f = {5'h00, 5'h10, 5'h10, 5'h10};
      default: f = {5'h10, 5'h10, 5'h10, 5'h10};
    endcase
    return f;
  endfunction

  // ***********************************************************
  // index / data port handling
  // ***********************************************************
  // cpu strobes are synchronous to CLK, so no synchroniser here
  assign wr_index = IO_WR && (IO_ADDR == PORT_INDEX);           // R1
  assign acc_data = (IO_WR || IO_RD) && (IO_ADDR == PORT_DATA); // R1
  assign slot_hit = state_r.idx_vld ? slot_of(state_r.idx) : 5'h00;

  // next state: one write or read per index load, then forget it
  always_comb begin
    state_nxt = state_r;
    state_nxt.rvalid = 1'b0;
    state_nxt.sw_meta = DETURBO_SW;
    state_nxt.sw_sync = state_r.sw_meta;
    if (wr_index) begin
      state_nxt.idx = IO_WDATA;                                 // R1
      state_nxt.idx_vld = 1'b1;
    end else if (acc_data) begin
      // a data access without a fresh index writes no register and reads idle
      if (IO_WR && slot_hit[4]) begin
        state_nxt.regs[slot_hit[3:0]] = IO_WDATA;               // R1
      end
      if (IO_RD) begin
        state_nxt.rvalid = 1'b1;
        state_nxt.rdata = slot_hit[4] ?
                          state_r.regs[slot_hit[3:0]] : READ_IDLE;
      end
      state_nxt.idx_vld = 1'b0;                                 // R2
      state_nxt.idx = 8'h00;                                    // R2
    end
  end

  // single register stage; reset restores every default
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r.idx <= 8'h00;
      state_r.idx_vld <= 1'b0;
      state_r.regs <= REG_RESET;                                // R26
      state_r.rdata <= 8'h00;
      state_r.rvalid <= 1'b0;
      state_r.sw_meta <= 1'b0;
      state_r.sw_sync <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign IO_RDATA = state_r.rdata;
  assign IO_RVALID = state_r.rvalid;

  // ***********************************************************
  // decoded settings
  // ***********************************************************
  assign r_dram = state_r.regs[S_DRAM];
  assign r_cache = state_r.regs[S_CACHE];
  assign r_shad = state_r.regs[S_SHAD];
  assign r_rom = state_r.regs[S_ROM];
  assign r_ncsz = state_r.regs[S_NCSZ];
  assign r_emu = state_r.regs[S_EMU];
  assign r_misc = state_r.regs[S_MISC];
  assign r_bclk = state_r.regs[S_BCLK];
  assign r_brec = state_r.regs[S_BREC];

  // dram geometry; speed bits 7:6 belong to the dram engine
  assign CAS_WR_1T = r_dram[5];                                 // R3
  assign banks = bank_map(r_dram[4:0]);                         // R4
  assign BANK0_MB = banks[4:0];
  assign BANK1_MB = banks[9:5];
  assign BANK2_MB = banks[14:10];
  assign BANK3_MB = banks[19:15];
  assign TOTAL_MB = {2'b00, BANK0_MB} + {2'b00, BANK1_MB}
                  + {2'b00, BANK2_MB} + {2'b00, BANK3_MB};      // R4

  // cache; bit 0 is trusted as written, a 386 board must set it
  assign CACHE_EN = r_cache[7];                                 // R5
  assign CACHE_WB = r_cache[6];                                 // R5
  assign CACHE_SIZE = r_cache[5:4];                             // R6
  assign CACHE_INTLV = r_cache[3];                              // R5
  assign CACHE_ON = r_cache[2];                                 // R5
  assign CACHE_WR_2T = r_cache[1];
  assign CACHE_BURST_2T = r_cache[0];                           // R7
  assign FORCE_HIT = r_emu[0];                                  // R21

  // shadow and rom mapping
  assign SHADOW_RD_EN = r_shad[7];                              // R8
  assign SHADOW_WP = r_shad[6];                                 // R8
  assign SHADOW_SEG = r_shad[5:0];                              // R9
  assign ROM_128K = r_rom[7];                                   // R10
  assign ROM_MERGE_C0 = r_rom[6];                               // R10
  assign ROM_MERGE_C8 = r_misc[2];                              // R10
  assign BIOS_CACHEABLE = r_rom[5];                             // R11
  assign C0_CACHEABLE = r_rom[4];                               // R11
  assign DMA_A25_24 = r_rom[3:2];                               // R12
  assign PARITY_EN = r_rom[1];                                  // R13

  // forced turbo overrides both the pin and the software request
  assign DETURBO = !r_rom[0] && (state_r.sw_sync || r_emu[1]);  // R14
  assign DETURBO_HOLD_CYC = r_misc[4] ? DT_HOLD8_CYC
                                      : DT_HOLD4_CYC;           // R14
  assign DETURBO_PERIOD_CYC = DT_PER_CYC;                       // R14

  // noncacheable areas; area 1 lives below 16mb so a25:a24 are 0
  assign NC1_TO_AT = r_ncsz[7];                                 // R15
  assign NC2_TO_AT = r_ncsz[3];                                 // R15
  assign NC1_SIZE_64K = nc_size(r_ncsz[6:4]);                   // R16
  assign NC2_SIZE_64K = nc_size(r_ncsz[2:0]);                   // R16
  assign NC1_BASE = {2'b00, state_r.regs[S_NC1B]};              // R17
  assign NC2_BASE = {r_emu[7:6], state_r.regs[S_NC2B]};         // R17

  // emulation, refresh and cpu options
  assign A20_EMU_EN = r_emu[5];                                 // R18
  assign FAST_RST_EN = r_emu[4];                                // R19
  assign FAST_RST_LAT_CYC = r_emu[3] ? FRST_LONG_CYC
                                     : FRST_SHORT_CYC;          // R19
  assign SLOW_REFRESH = r_emu[2];                               // R20
  assign SLOW_CPU = r_misc[7];                                  // R22
  assign DRAM_WR_0WS = r_misc[6];                               // R22

  // at bus clock; divide code 0 means the fixed 7.159 mhz source
  assign AT_CLK_FIXED = (r_bclk[7:5] == 3'h0);                  // R23
  assign AT_CLK_DIV = BCLK_DIV_TAB[r_bclk[7:5]];                // R23
  assign IO16_RECOVERY = REC16_TAB[r_brec[7:6]];                // R24
  assign IO8_RECOVERY = REC8_TAB[r_brec[5:4]];                  // R24
  assign WAIT16 = r_brec[2] ? WAIT16_FAST : WAIT16_SLOW;        // R25
  assign WAIT8 = r_brec[1] ? WAIT8_FAST : WAIT8_SLOW;           // R25

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_index_set;
    wr_index;
  endsequence

  sequence s_data_write;
    IO_WR && (IO_ADDR == PORT_DATA) && state_r.idx_vld;
  endsequence

  a_index_load: assert property (s_index_set |=> state_r.idx_vld // R1
    && state_r.idx == $past(IO_WDATA))
    else $error("index not captured");

  a_index_clear: assert property (acc_data |=> !state_r.idx_vld) // R2
    else $error("index kept after data access");

  a_write_lands: assert property (s_data_write ##0 slot_hit[4] // R1
    |=> state_r.regs[$past(slot_hit[3:0])] == $past(IO_WDATA))
    else $error("data write lost");

  a_stale_write: assert property (IO_WR && IO_ADDR == PORT_DATA // R2
    && !state_r.idx_vld |=> $stable(state_r.regs))
    else $error("write without index changed a register");

  a_read_answer: assert property (IO_RD && IO_ADDR == PORT_DATA // R1
    && slot_hit[4] |=> IO_RVALID
    && IO_RDATA == $past(state_r.regs[slot_hit[3:0]]))
    else $error("read returned wrong data");

  a_rvalid_only: assert property (!(IO_RD && IO_ADDR == PORT_DATA) // R1
    |=> !IO_RVALID)
    else $error("read answer without a data read");

  a_mem_total: assert property (TOTAL_MB != 7'h00 // R4
    && TOTAL_MB <= 7'h40)
    else $error("total memory out of range");

  a_nc_disable: assert property ((r_ncsz[6:4] == 3'h0) // R16
    == (NC1_SIZE_64K == 7'h00))
    else $error("area 1 size code 0 not disabled");

  a_turbo_force: assert property (r_rom[0] |-> !DETURBO) // R14
    else $error("forced turbo still de-turbo");

  a_at_bus_clock_div: assert property (!AT_CLK_FIXED // R23
    |-> AT_CLK_DIV >= 4'h2 && AT_CLK_DIV <= 4'hA)
    else $error("bus clock divisor out of range");

  a_reset_dflt: assert property (disable iff (1'b0) // R26
    $past(RST) |-> state_r.regs == REG_RESET && !state_r.idx_vld)
    else $error("defaults not loaded at reset");

endmodule

// ### inc/cfg_regs_pkg.sv
// shared constants for the indexed configuration register bank
package cfg_regs_pkg;

  // ***********************************************************
  // i/o ports of the index scheme
  // ***********************************************************
  localparam logic [15:0] PORT_INDEX = 16'h0022;
  localparam logic [15:0] PORT_DATA  = 16'h0023;
  localparam logic [7:0]  READ_IDLE  = 8'hFF;

  // ***********************************************************
  // register indices and storage slots
  // ***********************************************************
  localparam int          NUM_REGS  = 11;
  localparam logic [7:0]  IDX_DRAM  = 8'h50;
  localparam logic [7:0]  IDX_CACHE = 8'h51;
  localparam logic [7:0]  IDX_SHAD  = 8'h52;
  localparam logic [7:0]  IDX_ROM   = 8'h53;
  localparam logic [7:0]  IDX_NCSZ  = 8'h54;
  localparam logic [7:0]  IDX_NC1B  = 8'h55;
  localparam logic [7:0]  IDX_NC2B  = 8'h56;
  localparam logic [7:0]  IDX_EMU   = 8'h57;
  localparam logic [7:0]  IDX_MISC  = 8'h58;
  localparam logic [7:0]  IDX_BCLK  = 8'h60;
  localparam logic [7:0]  IDX_BREC  = 8'h61;

  localparam logic [3:0]  S_DRAM  = 4'h0;
  localparam logic [3:0]  S_CACHE = 4'h1;
  localparam logic [3:0]  S_SHAD  = 4'h2;
  localparam logic [3:0]  S_ROM   = 4'h3;
  localparam logic [3:0]  S_NCSZ  = 4'h4;
  localparam logic [3:0]  S_NC1B  = 4'h5;
  localparam logic [3:0]  S_NC2B  = 4'h6;
  localparam logic [3:0]  S_EMU   = 4'h7;
  localparam logic [3:0]  S_MISC  = 4'h8;
  localparam logic [3:0]  S_BCLK  = 4'h9;
  localparam logic [3:0]  S_BREC  = 4'hA;

  // reset values, slot 10 down to slot 0
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
    8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // ***********************************************************
  // bus timing encodings
  // ***********************************************************
  localparam logic [3:0][3:0] REC16_TAB = {4'h2, 4'h3, 4'h5, 4'h8};
  localparam logic [3:0][4:0] REC8_TAB  = {5'h04, 5'h07, 5'h0B, 5'h10};
  localparam logic [7:0][3:0] BCLK_DIV_TAB = {
    4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'h0};
  localparam logic [1:0] WAIT16_SLOW = 2'h2;
  localparam logic [1:0] WAIT16_FAST = 2'h1;
  localparam logic [2:0] WAIT8_SLOW  = 3'h5;
  localparam logic [2:0] WAIT8_FAST  = 3'h4;

  // ***********************************************************
  // timing counts at the system clock
  // ***********************************************************
  localparam int CLK_MHZ          = 250;
  localparam int FRST_SHORT_NS    = 2000;
  localparam int FRST_LONG_NS     = 6000;
  localparam int DETURBO_HOLD4_NS = 4000;
  localparam int DETURBO_HOLD8_NS = 8000;
  localparam int DETURBO_PER_NS   = 12000;
  localparam logic [11:0] FRST_SHORT_CYC =
    12'((FRST_SHORT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] FRST_LONG_CYC =
    12'((FRST_LONG_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] DT_HOLD4_CYC =
    12'((DETURBO_HOLD4_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] DT_HOLD8_CYC =
    12'((DETURBO_HOLD8_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] DT_PER_CYC =
    12'((DETURBO_PER_NS * CLK_MHZ + 999) / 1000);

endpackage

// ### testbench/testbench.sv
// self-checking bench for the indexed configuration register bank
`timescale 1ns/100ps
module testbench
  import cfg_regs_pkg::*;
;
  logic        CLK, RST, IO_WR, IO_RD, IO_RVALID, DETURBO_SW;
  logic [15:0] IO_ADDR;
  logic [7:0]  IO_WDATA, IO_RDATA;
  logic        CAS_WR_1T, CACHE_EN, CACHE_WB, CACHE_INTLV, CACHE_ON;
  logic        CACHE_WR_2T, CACHE_BURST_2T, FORCE_HIT, SHADOW_RD_EN;
  logic        SHADOW_WP, ROM_128K, ROM_MERGE_C0, ROM_MERGE_C8;
  logic        BIOS_CACHEABLE, C0_CACHEABLE, PARITY_EN, DETURBO;
  logic        NC1_TO_AT, NC2_TO_AT, A20_EMU_EN, FAST_RST_EN;
  logic        SLOW_REFRESH, SLOW_CPU, DRAM_WR_0WS, AT_CLK_FIXED;
  logic [4:0]  BANK0_MB, BANK1_MB, BANK2_MB, BANK3_MB, IO8_RECOVERY;
  logic [6:0]  TOTAL_MB, NC1_SIZE_64K, NC2_SIZE_64K;
  logic [1:0]  CACHE_SIZE, DMA_A25_24, WAIT16;
  logic [5:0]  SHADOW_SEG;
  logic [11:0] DETURBO_HOLD_CYC, DETURBO_PERIOD_CYC, FAST_RST_LAT_CYC;
  logic [9:0]  NC1_BASE, NC2_BASE;
  logic [3:0]  AT_CLK_DIV, IO16_RECOVERY;
  logic [2:0]  WAIT8;
  int          failures, tests_run;
  logic [7:0]  idx_tab [11] = '{IDX_DRAM, IDX_CACHE, IDX_SHAD, IDX_ROM,
    IDX_NCSZ, IDX_NC1B, IDX_NC2B, IDX_EMU, IDX_MISC, IDX_BCLK, IDX_BREC};

  chipset_config_registers i_chipset_config_registers (
    .CLK, .RST, .IO_ADDR, .IO_WR, .IO_RD, .IO_WDATA, .IO_RDATA, .IO_RVALID,
    .DETURBO_SW, .CAS_WR_1T, .BANK0_MB, .BANK1_MB, .BANK2_MB, .BANK3_MB,
    .TOTAL_MB, .CACHE_EN, .CACHE_WB, .CACHE_SIZE, .CACHE_INTLV, .CACHE_ON,
    .CACHE_WR_2T, .CACHE_BURST_2T, .FORCE_HIT, .SHADOW_RD_EN, .SHADOW_WP,
    .SHADOW_SEG, .ROM_128K, .ROM_MERGE_C0, .ROM_MERGE_C8, .BIOS_CACHEABLE,
    .C0_CACHEABLE, .DMA_A25_24, .PARITY_EN, .DETURBO, .DETURBO_HOLD_CYC,
    .DETURBO_PERIOD_CYC, .NC1_TO_AT, .NC1_SIZE_64K, .NC1_BASE, .NC2_TO_AT,
    .NC2_SIZE_64K, .NC2_BASE, .A20_EMU_EN, .FAST_RST_EN, .FAST_RST_LAT_CYC,
    .SLOW_REFRESH, .SLOW_CPU, .DRAM_WR_0WS, .AT_CLK_FIXED, .AT_CLK_DIV,
    .IO16_RECOVERY, .IO8_RECOVERY, .WAIT16, .WAIT8);

  // 250 MHz system clock
  always #2 CLK = ~CLK;

  // ************************************************************
  // shared bus cycles and comparison
  // ************************************************************
  task automatic finish_test();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle strobe; released on the edge that samples it
  task automatic io(input logic w, input logic [15:0] a,
                    input logic [7:0] d);
    @(posedge CLK);
    IO_WR <= w;
    IO_RD <= ~w;
    IO_ADDR <= a;
    IO_WDATA <= d;
    @(posedge CLK);
    IO_WR <= 1'b0;
    IO_RD <= 1'b0;
  endtask

  // data read; the answer is waited for under a bound
  task automatic get_rd(output logic [7:0] d);
    int n;
    n = 0;
    io(1'b0, PORT_DATA, 8'h00);
    #1;
    while (IO_RVALID !== 1'b1 && n < 4) begin
      @(posedge CLK);
      #1;
      n++;
    end
    if (n == 4) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, IO_RVALID, 1'b1);
      finish_test();
    end
    d = IO_RDATA;
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    io(1'b1, PORT_INDEX, idx);
    io(1'b1, PORT_DATA, d);
  endtask

  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d);
    io(1'b1, PORT_INDEX, idx);
    get_rd(d);
  endtask

  // decoded outputs follow one cycle after the data write
  task automatic settle();
    @(posedge CLK);
    #1;
  endtask

  function automatic logic [6:0] nc_size(input int c);
    return (c == 0) ? 7'h00 : 7'(1 << (c - 1));
  endfunction

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_defaults();
    logic [7:0] d;
    for (int i = 0; i < NUM_REGS; i++) begin
      rd_reg(idx_tab[i], d);
      chk(d, REG_RESET[i]);
    end
    chk({WAIT16, WAIT8, IO16_RECOVERY, IO8_RECOVERY},
        {2'h2, 3'h5, 4'h8, 5'h10});
    chk({AT_CLK_FIXED, TOTAL_MB, BANK0_MB, DETURBO},
        {1'b1, 7'h01, 5'h01, 1'b0});
  endtask

  // every register holds what was written; unmapped index reads idle
  task automatic t_readback();
    logic [7:0] d;
    for (int i = 0; i < NUM_REGS; i++) wr_reg(idx_tab[i], 8'hA5 ^ 8'(i));
    for (int i = 0; i < NUM_REGS; i++) begin
      rd_reg(idx_tab[i], d);
      chk(d, 8'hA5 ^ 8'(i));
    end
    settle();
    chk(IO_RVALID, 1'b0);
    wr_reg(8'h59, 8'h12);
    rd_reg(8'h59, d);
    chk(d, 8'hFF);
  endtask

  // the index is spent by one data access; a new index replaces the old
  task automatic t_index();
    logic [7:0] d;
    wr_reg(IDX_NC1B, 8'h3C);
    io(1'b1, PORT_DATA, 8'hC3);
    rd_reg(IDX_NC1B, d);
    chk(d, 8'h3C);
    get_rd(d);
    chk(d, 8'hFF);
    io(1'b1, PORT_INDEX, IDX_NC1B);
    wr_reg(IDX_NC2B, 8'h77);
    rd_reg(IDX_NC1B, d);
    chk(d, 8'h3C);
    rd_reg(IDX_NC2B, d);
    chk(d, 8'h77);
  endtask

  task automatic t_cache();
    logic [7:0] v;
    for (int c = 0; c < 4; c++) begin
      v = {c[0], ~c[0], 2'(c), c[1], ~c[1], c[0], ~c[0]};
      wr_reg(IDX_CACHE, v);
      settle();
      chk({CACHE_EN, CACHE_WB, CACHE_SIZE, CACHE_INTLV, CACHE_ON,
           CACHE_WR_2T, CACHE_BURST_2T}, v);
    end
  endtask

  task automatic t_dram();
    logic [4:0]  code [4] = '{5'h00, 5'h0F, 5'h16, 5'h1F};
    logic [26:0] ex [4] = '{{5'h01, 5'h00, 5'h00, 5'h00, 7'h01},
      {5'h02, 5'h02, 5'h10, 5'h10, 7'h24},
      {5'h04, 5'h10, 5'h10, 5'h00, 7'h24},
      {5'h10, 5'h10, 5'h10, 5'h10, 7'h40}};
    for (int i = 0; i < 4; i++) begin
      wr_reg(IDX_DRAM, {2'b00, i[0], code[i]});
      settle();
      chk({BANK0_MB, BANK1_MB, BANK2_MB, BANK3_MB, TOTAL_MB}, ex[i]);
      chk(CAS_WR_1T, i[0]);
    end
  endtask

  task automatic t_noncache();
    for (int c = 0; c < 8; c++) begin
      wr_reg(IDX_NCSZ, {c[0], 3'(c), ~c[0], 3'(7 - c)});
      settle();
      chk({NC1_TO_AT, NC1_SIZE_64K, NC2_TO_AT, NC2_SIZE_64K},
          {c[0], nc_size(c), ~c[0], nc_size(7 - c)});
    end
    wr_reg(IDX_NC1B, 8'h9A);
    wr_reg(IDX_NC2B, 8'h3C);
    wr_reg(IDX_EMU, 8'hC0);
    settle();
    chk({NC1_BASE, NC2_BASE}, {10'h09A, 10'h33C});
  endtask

  task automatic t_atbus();
    logic [3:0] dv [8] = '{4'h0, 4'hA, 4'h8, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2};
    logic [3:0] r16 [4] = '{4'h8, 4'h5, 4'h3, 4'h2};
    logic [4:0] r8 [4] = '{5'h10, 5'h0B, 5'h07, 5'h04};
    for (int c = 0; c < 8; c++) begin
      wr_reg(IDX_BCLK, {3'(c), 5'h00});
      settle();
      chk({AT_CLK_FIXED, AT_CLK_DIV}, {c == 0, dv[c]});
    end
    for (int c = 0; c < 4; c++) begin
      wr_reg(IDX_BREC, {2'(c), 2'(c), 1'b1, c[0], c[1], 1'b1});
      settle();
      chk({IO16_RECOVERY, IO8_RECOVERY, WAIT16, WAIT8}, {r16[c], r8[c],
          c[0] ? 2'h1 : 2'h2, c[1] ? 3'h4 : 3'h5});
    end
  endtask

  task automatic t_misc();
    wr_reg(IDX_SHAD, 8'h96);
    wr_reg(IDX_ROM, 8'hFE);
    wr_reg(IDX_MISC, 8'hD4);
    wr_reg(IDX_EMU, 8'h3D);
    settle();
    chk({SHADOW_RD_EN, SHADOW_WP, SHADOW_SEG}, 8'h96);
    chk({ROM_128K, ROM_MERGE_C0, BIOS_CACHEABLE, C0_CACHEABLE,
         DMA_A25_24, PARITY_EN}, 7'h7F);
    chk({SLOW_CPU, DRAM_WR_0WS, ROM_MERGE_C8, DETURBO_HOLD_CYC,
         DETURBO_PERIOD_CYC}, {3'b111, 12'h7D0, 12'hBB8});
    chk({A20_EMU_EN, FAST_RST_EN, FAST_RST_LAT_CYC, SLOW_REFRESH,
         FORCE_HIT}, {2'b11, 12'h5DC, 2'b11});
    // switch input crosses a two-flop synchroniser
    @(posedge CLK);
    DETURBO_SW <= 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    chk(DETURBO, 1'b1);
    wr_reg(IDX_ROM, 8'hFF);
    settle();
    chk(DETURBO, 1'b0);
    @(posedge CLK);
    DETURBO_SW <= 1'b0;
    wr_reg(IDX_ROM, 8'h56);
    wr_reg(IDX_EMU, 8'h02);
    wr_reg(IDX_MISC, 8'h00);
    settle();
    chk({DETURBO, FAST_RST_LAT_CYC, DETURBO_HOLD_CYC},
        {1'b1, 12'h1F4, 12'h3E8});
    // mixed pattern so a stuck or swapped field cannot pass unseen
    chk({ROM_128K, ROM_MERGE_C0, BIOS_CACHEABLE, C0_CACHEABLE, DMA_A25_24,
         PARITY_EN, ROM_MERGE_C8, A20_EMU_EN, FAST_RST_EN, SLOW_REFRESH,
         FORCE_HIT, SLOW_CPU, DRAM_WR_0WS}, 14'h1580);
  endtask

  // reset in mid-run restores defaults and drops a pending index
  task automatic t_reset();
    logic [7:0] d;
    io(1'b1, PORT_INDEX, IDX_BREC);
    RST <= 1'b1;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    get_rd(d);
    chk(d, 8'hFF);
    t_defaults();
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    CLK = 1'b0;
    RST = 1'b1;
    IO_WR = 1'b0;
    IO_RD = 1'b0;
    IO_ADDR = 16'h0000;
    IO_WDATA = 8'h00;
    DETURBO_SW = 1'b0;
    failures = 0;
    tests_run = 0;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    t_defaults();
    t_readback();
    t_index();
    t_cache();
    t_dram();
    t_noncache();
    t_atbus();
    t_misc();
    t_reset();
    finish_test();
  end
endmodule
